//--- verilog/irq_ops_pkg.sv
// Shared constants and carriers for the dual interrupt controller operation logic.
// Assumes one 100 MHz system clock and an 8-bit I/O port access interface.
package irq_ops_pkg;

	// I/O port addresses
	localparam logic [15:0] PORT_CTL1_BASE   = 16'h0020;
	localparam logic [15:0] PORT_CTL1_DATA   = 16'h0021;
	localparam logic [15:0] PORT_CTL2_BASE   = 16'h00A0;
	localparam logic [15:0] PORT_CTL2_DATA   = 16'h00A1;
	localparam logic [15:0] PORT_TRIG_LOW    = 16'h04D0;
	localparam logic [15:0] PORT_TRIG_HIGH   = 16'h04D1;

	// Command word field positions
	localparam int BIT_INIT_SEL    = 4;
	localparam int BIT_CMD3_SEL    = 3;
	localparam int BIT_ROTATE      = 7;
	localparam int BIT_SPECIFIC    = 6;
	localparam int BIT_EOI         = 5;
	localparam int BIT_SMM         = 6;
	localparam int BIT_SPECIAL_MASK_ENABLE        = 5;
	localparam int BIT_POLL        = 2;
	localparam int BIT_RD_ACT      = 1;
	localparam int BIT_RD_SEL      = 0;

	// Trigger select reset values and fixed-edge lines; common byte, level and poll values
	localparam logic [7:0] TRIG_RESET      = 8'h00;
	localparam logic [7:0] TRIG_LOW_MASK   = 8'hF8;
	localparam logic [7:0] TRIG_HIGH_MASK  = 8'hDE;
	localparam logic [7:0] BYTE_ZERO       = 8'h00;
	localparam logic [2:0] LEVEL_ZERO      = 3'h0;
	localparam logic [2:0] LEVEL_LOWEST    = 3'h7;
	localparam logic [7:0] POLL_VALID      = 8'h80;

	// Rotate / end-of-interrupt command codes (bits 7..5)
	typedef enum logic [2:0] {
		CMD_ROT_AEOI_CLR = 3'h0,
		CMD_EOI_NONSPEC  = 3'h1,
		CMD_NOP          = 3'h2,
		CMD_EOI_SPEC     = 3'h3,
		CMD_ROT_AEOI_SET = 3'h4,
		CMD_ROT_NONSPEC  = 3'h5,
		CMD_SET_PRIO     = 3'h6,
		CMD_ROT_SPEC     = 3'h7
	} rot_cmd_t;

	// One I/O port access
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} io_req_t;

	// Per-controller port strobes
	typedef struct packed {
		logic       base_wr;
		logic       base_rd;
		logic       data_wr;
		logic       data_rd;
		logic [7:0] wdata;
	} ctl_req_t;

endpackage

//--- verilog/trigger_sense.sv
// Edge or level request capture for eight interrupt lines.
// Assumes the lines are synchronous to sys_clk.
`timescale 1ns/1ns
`default_nettype none
module trigger_sense #(
	parameter int WIDTH = 8
) (
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] irq_line,
	input  wire logic [WIDTH-1:0] level_sel,
	input  wire logic [WIDTH-1:0] mask,
	input  wire logic [WIDTH-1:0] clear,
	output logic      [WIDTH-1:0] pending
);
	import irq_ops_pkg::*;

	logic [WIDTH-1:0] line_prev_reg;
	logic [WIDTH-1:0] edge_reg;
	wire  [WIDTH-1:0] rise = irq_line & ~line_prev_reg;

	// Edge capture is sticky; a rising edge wins over a clear in the same cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			line_prev_reg <= '0;
			edge_reg      <= '0;
		end else begin
			line_prev_reg <= irq_line;
			edge_reg      <= (edge_reg & ~clear) | (rise & ~mask); // R18
		end
	end

	// Level lines follow the pin while unmasked; masked lines never show
	assign pending = ((edge_reg & ~level_sel) | (irq_line & level_sel)) & ~mask; // R18
endmodule
`default_nettype wire

//--- verilog/ctl_core.sv
// One controller's operation-word decode, status select, priority and service state.
// Assumes port strobes already decoded by the top; one access per cycle.
`timescale 1ns/1ns
`default_nettype none
module ctl_core (
	input  wire logic                  sys_clk,
	input  wire logic                  rst_n,
	input  wire irq_ops_pkg::ctl_req_t req,
	input  wire logic [7:0]            irq_line,
	input  wire logic [7:0]            level_sel,
	output logic [7:0]                 rdata,
	output logic                       int_out,
	output logic                       smm_active
);
	import irq_ops_pkg::*;

	logic [7:0] mask_reg;
	logic [7:0] isr_reg;
	logic [2:0] lowest_reg;
	logic       read_isr_reg;
	logic       special_mask_enable_reg;
	logic       smm_reg;
	logic       poll_reg;
	logic       auto_rotate_reg;
	logic [1:0] init_step_reg;
	logic [7:0] clear_pend;
	wire  [7:0] request_register;

	trigger_sense #(.WIDTH(8)) u_sense (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.irq_line  (irq_line),
		.level_sel (level_sel),
		.mask      (mask_reg),
		.clear     (clear_pend),
		.pending   (request_register)
	);

	// Highest-priority line in a vector, counted after the lowest-priority level
	function automatic logic [3:0] pick(input logic [7:0] v, input logic [2:0] low);
		logic [3:0] res;
		logic [2:0] idx;
		res = 4'h8;
		for (int i = 7; i >= 0; i--) begin
			idx = 3'(low + 3'(i) + 3'h1);
			if (v[idx])
				res = {1'b0, idx};
		end
		return res;
	endfunction

	// Word class decode
	wire        is_init   = req.base_wr & req.wdata[BIT_INIT_SEL];                       // R15
	wire        is_cmd2   = req.base_wr & ~req.wdata[BIT_INIT_SEL] & ~req.wdata[BIT_CMD3_SEL]; // R3
	wire        is_cmd3   = req.base_wr & ~req.wdata[BIT_INIT_SEL] & req.wdata[BIT_CMD3_SEL];  // R4
	wire [2:0]  code      = req.wdata[7:5];                                            // R14
	wire        specific  = req.wdata[BIT_SPECIFIC];
	wire [2:0]  lvl_field = req.wdata[2:0];
	wire        smm_eff   = special_mask_enable_reg & smm_reg;                                        // R5
	wire [7:0]  isr_block = smm_eff ? 8'h00 : isr_reg;
	wire [3:0]  top_isr   = pick(isr_reg, lowest_reg);
	wire [3:0]  top_req   = pick(request_register & ~(smm_eff ? isr_reg : BYTE_ZERO), lowest_reg);
	wire [3:0]  top_blk   = pick(isr_block, lowest_reg);
	wire        req_wins  = ~top_req[3] & (top_blk[3] | (3'(top_req[2:0] - lowest_reg - 3'h1)
		< 3'(top_blk[2:0] - lowest_reg - 3'h1)));
	wire [2:0]  target    = specific ? lvl_field : top_isr[2:0];                      // R2
	wire        eoi_hit   = is_cmd2 & (code == CMD_EOI_NONSPEC | code == CMD_EOI_SPEC
		| code == CMD_ROT_NONSPEC | code == CMD_ROT_SPEC);                             // R1
	wire        nonspec_ok = specific | ~top_isr[3];
	wire        poll_read = req.base_rd & poll_reg;                                    // R6
	wire [7:0]  one_hot   = 8'h01 << target;
	wire [7:0]  poll_hot  = 8'h01 << top_req[2:0];

	// Acknowledge on poll read; edge request then clears
	assign clear_pend = (poll_read & ~top_req[3]) ? poll_hot : BYTE_ZERO;

	// Configuration and mode flags
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_reg        <= BYTE_ZERO;
			read_isr_reg    <= 1'b0;
			special_mask_enable_reg        <= 1'b0;
			smm_reg         <= 1'b0;
			poll_reg        <= 1'b0;
			auto_rotate_reg <= 1'b0;                                                   // R17
			lowest_reg      <= LEVEL_LOWEST;                                           // R17
			init_step_reg   <= 2'h0;
		end else if (is_init) begin
			mask_reg        <= BYTE_ZERO;
			read_isr_reg    <= 1'b0;                                                   // R16 R8
			smm_reg         <= 1'b0;                                                   // R16
			special_mask_enable_reg        <= 1'b0;
			poll_reg        <= 1'b0;
			auto_rotate_reg <= 1'b0;                                                   // R17
			lowest_reg      <= LEVEL_LOWEST;                                           // R17
			init_step_reg   <= 2'h3;
		end else begin
			if (req.data_wr && init_step_reg != 2'h0)
				init_step_reg <= 2'(init_step_reg - 2'h1);
			else if (req.data_wr)
				mask_reg <= req.wdata;
			if (is_cmd3) begin
				// Enable clear leaves the mask mode as it stands
				if (req.wdata[BIT_SPECIAL_MASK_ENABLE]) begin
					special_mask_enable_reg <= 1'b1;                                                   // R5
					smm_reg  <= req.wdata[BIT_SMM];                                     // R5
				end
				if (req.wdata[BIT_RD_ACT])
					read_isr_reg <= req.wdata[BIT_RD_SEL];                              // R7 R9
				poll_reg <= req.wdata[BIT_POLL];                                       // R6
			end else if (req.base_rd)
				poll_reg <= 1'b0;
			if (is_cmd2 && code == CMD_ROT_AEOI_SET)
				auto_rotate_reg <= 1'b1;                                               // R1
			if (is_cmd2 && code == CMD_ROT_AEOI_CLR)
				auto_rotate_reg <= 1'b0;                                               // R1
			if (is_cmd2 && code == CMD_SET_PRIO)
				lowest_reg <= lvl_field;                                               // R1 R2
			if (is_cmd2 && (code == CMD_ROT_NONSPEC || code == CMD_ROT_SPEC) && nonspec_ok)
				lowest_reg <= target;                                                  // R1
			// Auto rotation: the line just acknowledged drops to lowest priority
			if (poll_read && !top_req[3] && auto_rotate_reg)
				lowest_reg <= top_req[2:0];                                            // R1
		end
	end

	// In-service state: poll acknowledge sets unless auto rotate is on, end-of-interrupt clears
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			isr_reg <= BYTE_ZERO;
		else if (is_init)
			isr_reg <= BYTE_ZERO;
		else if (poll_read && !top_req[3] && !auto_rotate_reg)
			isr_reg <= isr_reg | poll_hot;
		else if (eoi_hit && nonspec_ok)
			isr_reg <= isr_reg & ~one_hot;                                             // R1 R2
	end

	// Read data: poll answer, selected status register, or the mask on the data port
	logic [7:0] rdata_next;
	always_comb begin
		rdata_next = mask_reg;
		if (poll_read)
			rdata_next = top_req[3] ? BYTE_ZERO : (POLL_VALID | {5'h0, top_req[2:0]}); // R6
		else if (req.base_rd)
			rdata_next = read_isr_reg ? isr_reg : request_register;                                 // R7 R8 R9
	end

	assign rdata      = rdata_next;
	assign int_out    = req_wins;
	assign smm_active = smm_eff;
endmodule
`default_nettype wire

//--- verilog/dual_irq_ops.sv
// Top of the cascaded interrupt controller operation logic: port decode, trigger select.
// Assumes I/O accesses are one-cycle strobes synchronous to sys_clk.
//
// Operation
// (R1) Rotate/END_OF_INTERRUPT word bits 7..5 pick clear/set auto rotate, EOIs, nop, priority.
// (R2) Low three bits name the target level only when the specific bit is set.
// (R3) Host writes zeros in bits 4..3 for the rotate/END_OF_INTERRUPT word.
// (R4) Host writes 01 in bits 4..3 and zero bit 7 for the mask/poll word.
// (R5) Special mask mode needs both enable and mask bit set.
// (R6) Poll bit makes the next base read an acknowledge returning top request.
// (R7) Read field 10 selects request register, 11 in-service, others keep selection.
// (R8) After initialization base reads return the request register.
// (R9) The selected status register stays selected for every later base read.
// (R10) Low trigger select bits 7..3 pick edge (0) or high level (1).
// (R11) Lines 0..2 are always edge; their select bits are forced zero.
// (R12) High trigger select bits 7,6,4..1 pick edge or level for lines 15,14,12..9.
// (R13) Lines 13 and 8 are always edge; bits 5 and 0 forced zero.
// (R14) Word bit 7 is rotate, bit 6 specific level, bit 5 end of interrupt.
// (R15) Base write with bit 4 set is always the first initialization word.
// (R16) First initialization word clears special mask and selects request reads.
// (R17) Reset or initialization gives fully nested priority, no rotation.
// (R18) Edge lines latch on rising edge; level lines pend while high and unmasked. Here a rising edge latches only while its line is unmasked.
`timescale 1ns/1ns
`default_nettype none
module dual_irq_ops (
	input  wire logic                 sys_clk,
	input  wire logic                 rst_n,
	input  wire irq_ops_pkg::io_req_t io,
	input  wire logic [15:0]          irq_in,
	output logic [7:0]                io_rdata,
	output logic                      cpu_int,
	output logic                      special_mask_low,
	output logic                      special_mask_high
);
	import irq_ops_pkg::*;

	//--------------------------------------------------------------
	// Port decode
	//--------------------------------------------------------------
	logic [7:0] trig_low_reg;
	logic [7:0] trig_high_reg;
	logic [7:0] io_rdata_reg;
	logic       cpu_int_reg;
	logic       smm_low_reg;
	logic       smm_high_reg;
	wire  [7:0] rdata1;
	wire  [7:0] rdata2;
	wire        int1;
	wire        int2;
	wire        smm1;
	wire        smm2;

	wire hit1b = io.addr == PORT_CTL1_BASE;
	wire hit1d = io.addr == PORT_CTL1_DATA;
	wire hit2b = io.addr == PORT_CTL2_BASE;
	wire hit2d = io.addr == PORT_CTL2_DATA;
	wire hit_tl = io.addr == PORT_TRIG_LOW;
	wire hit_th = io.addr == PORT_TRIG_HIGH;

	// Strobes per controller
	wire ctl_req_t req1 = '{base_wr: io.wr & hit1b, base_rd: io.rd & hit1b,
		data_wr: io.wr & hit1d, data_rd: io.rd & hit1d, wdata: io.wdata};
	wire ctl_req_t req2 = '{base_wr: io.wr & hit2b, base_rd: io.rd & hit2b,
		data_wr: io.wr & hit2d, data_rd: io.rd & hit2d, wdata: io.wdata};

	//--------------------------------------------------------------
	// Trigger select registers
	//--------------------------------------------------------------
	// Fixed-edge positions are forced zero so a careless write cannot make them level
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			trig_low_reg  <= TRIG_RESET;
			trig_high_reg <= TRIG_RESET;
		end else begin
			if (io.wr && hit_tl)
				trig_low_reg <= io.wdata & TRIG_LOW_MASK;                              // R10 R11
			if (io.wr && hit_th)
				trig_high_reg <= io.wdata & TRIG_HIGH_MASK;                            // R12 R13
		end
	end

	//--------------------------------------------------------------
	// Controllers
	//--------------------------------------------------------------
	ctl_core u_ctl1 (
		.sys_clk    (sys_clk),
		.rst_n      (rst_n),
		.req        (req1),
		.irq_line   ({irq_in[7:3], int2, irq_in[1:0]}),
		.level_sel  (trig_low_reg),                                                    // R10
		.rdata      (rdata1),
		.int_out    (int1),
		.smm_active (smm1)
	);

	ctl_core u_ctl2 (
		.sys_clk    (sys_clk),
		.rst_n      (rst_n),
		.req        (req2),
		.irq_line   (irq_in[15:8]),
		.level_sel  (trig_high_reg),                                                   // R12
		.rdata      (rdata2),
		.int_out    (int2),
		.smm_active (smm2)
	);

	//--------------------------------------------------------------
	// Read mux and registered outputs
	//--------------------------------------------------------------
	// Unmapped reads answer zero; data registered so all outputs come from flops
	wire [7:0] rd_mux = (hit1b | hit1d) ? rdata1 :
		(hit2b | hit2d) ? rdata2 :
		hit_tl ? trig_low_reg :
		hit_th ? trig_high_reg : BYTE_ZERO;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			io_rdata_reg <= BYTE_ZERO;
			cpu_int_reg  <= 1'b0;
			smm_low_reg  <= 1'b0;
			smm_high_reg <= 1'b0;
		end else begin
			if (io.rd)
				io_rdata_reg <= rd_mux;
			cpu_int_reg  <= int1;
			smm_low_reg  <= smm1;                                                      // R5
			smm_high_reg <= smm2;
		end
	end

	assign io_rdata          = io_rdata_reg;
	assign cpu_int           = cpu_int_reg;
	assign special_mask_low  = smm_low_reg;
	assign special_mask_high = smm_high_reg;
endmodule
`default_nettype wire

//--- verification/dual_irq_ops_props.sv
// Assertions on the ports of the dual interrupt controller top.
// Bound to dual_irq_ops; one clock domain, reset active low.
`timescale 1ns/1ns
`default_nettype none
module dual_irq_ops_props (
	input wire logic                 sys_clk,
	input wire logic                 rst_n,
	input wire irq_ops_pkg::io_req_t io,
	input wire logic [15:0]          irq_in,
	input wire logic [7:0]           io_rdata,
	input wire logic                 cpu_int,
	input wire logic                 special_mask_low,
	input wire logic                 special_mask_high
);
	import irq_ops_pkg::*;
	// --------------------------------
	// Decoded host writes and base read
	// --------------------------------
	wire logic base1_wr = io.wr && io.addr == PORT_CTL1_BASE;
	wire logic base2_wr = io.wr && io.addr == PORT_CTL2_BASE;
	wire logic mpr1_wr  = base1_wr && io.wdata[4:3] == 2'h1;
	wire logic mpr2_wr  = base2_wr && io.wdata[4:3] == 2'h1;
	wire logic base1_rd = io.rd && io.addr == PORT_CTL1_BASE;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	a_rdata_hold: assert property (!io.rd |=> $stable(io_rdata))
		else $error("read data moved without a read");
	a_low_fixed_edge: assert property (io.rd && io.addr == PORT_TRIG_LOW |=> io_rdata[2:0] == 3'h0)
		else $error("low trigger bits 2..0 not zero");
	a_high_fixed_edge: assert property (io.rd && io.addr == PORT_TRIG_HIGH |=>
		!io_rdata[5] && !io_rdata[0])
		else $error("high trigger bits 5 or 0 not zero");
	// Mode flags reach the pins two edges after the write is taken
	a_smm_enter_low: assert property (mpr1_wr && io.wdata[6:5] == 2'h3 |=> ##1 special_mask_low)
		else $error("special mask not entered");
	a_smm_normal_low: assert property (mpr1_wr && io.wdata[6:5] == 2'h1 |=> ##1 !special_mask_low)
		else $error("special mask not left");
	a_smm_ignored_low: assert property (mpr1_wr && !io.wdata[5] |=> ##1 $stable(special_mask_low))
		else $error("special mask moved with enable clear");
	a_smm_enter_high: assert property (mpr2_wr && io.wdata[6:5] == 2'h3 |=> ##1 special_mask_high)
		else $error("second special mask not entered");
	a_init_clear_low: assert property (base1_wr && io.wdata[4] |=> ##1 !special_mask_low)
		else $error("init word left special mask on");
	a_init_clear_high: assert property (base2_wr && io.wdata[4] |=> ##1 !special_mask_high)
		else $error("second init word left special mask on");
	a_cmd2_keeps_smm: assert property (base1_wr && io.wdata[4:3] == 2'h0 |=>
		##1 $stable(special_mask_low))
		else $error("rotate word touched special mask");
	a_poll_ack_form: assert property (mpr1_wr && io.wdata[2] ##1 base1_rd |=>
		io_rdata[6:3] == 4'h0)
		else $error("poll answer malformed");
endmodule
bind dual_irq_ops dual_irq_ops_props u_props (.sys_clk(sys_clk), .rst_n(rst_n), .io(io),
	.irq_in(irq_in), .io_rdata(io_rdata), .cpu_int(cpu_int),
	.special_mask_low(special_mask_low), .special_mask_high(special_mask_high));
`default_nettype wire

//--- verification/io_host.sv
// Host processor model making byte I/O reads and writes.
// Assumes its tasks are called at or after a falling clock edge.
`timescale 1ns/1ns
`default_nettype none
module io_host (
	input  wire logic            sys_clk,
	input  wire logic [7:0]      io_rdata,
	output irq_ops_pkg::io_req_t io
);
	import irq_ops_pkg::*;
	// --------------------------------
	// Port cycles
	// --------------------------------
	initial io = '0;
	// Released lines flip so a stale address never looks valid
	task automatic idle;
		io.wr = 1'b0;
		io.rd = 1'b0;
		io.addr = ~io.addr;
		io.wdata = ~io.wdata;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		io.addr = a;
		io.wdata = d;
		io.wr = 1'b1;
		@(negedge sys_clk);
		idle();
	endtask
	// Data is taken a full cycle after release, safe for either latency
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(negedge sys_clk);
		io.addr = a;
		io.rd = 1'b1;
		@(negedge sys_clk);
		idle();
		@(negedge sys_clk);
		d = io_rdata;
	endtask
	task automatic cmd2(input logic [15:0] a, input logic [7:0] d);
		wr(a, d & 8'hE7);
	endtask
	task automatic cmd3(input logic [15:0] a, input logic [7:0] d);
		wr(a, (d & 8'h67) | 8'h08);
	endtask
	// Poll word then the acknowledging read, back to back
	task automatic poll(input logic [15:0] a, output logic [7:0] d);
		@(negedge sys_clk);
		io.addr = a;
		io.wdata = 8'h0C;
		io.wr = 1'b1;
		@(negedge sys_clk);
		io.wr = 1'b0;
		io.rd = 1'b1;
		@(negedge sys_clk);
		idle();
		@(negedge sys_clk);
		d = io_rdata;
	endtask
endmodule
`default_nettype wire

//--- verification/dual_irq_ops_bench.sv
// Self-checking bench for dual_irq_ops driven through the host model.
// Assumes one 100 MHz clock; inputs change on falling edges.
`timescale 1ns/1ns
`default_nettype none
module dual_irq_ops_bench;
	import irq_ops_pkg::*;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [15:0] irq_in = 16'h0000;
	io_req_t     io;
	logic [7:0]  io_rdata;
	logic        cpu_int;
	logic        special_mask_low;
	logic        special_mask_high;
	logic [7:0]  got;
	int          mismatches = 0;
	int          n_tests = 0;
	int          cycles = 0;
	// Address, written byte, expected read-back
	logic [31:0] rows [0:6] = '{32'h04D0FFF8, 32'h04D1FFDE, 32'h04D05750,
		32'h04D12100, 32'h0123FF00, 32'h04D00000, 32'h04D10000};

	io_host u_io_host (.sys_clk(sys_clk), .io_rdata(io_rdata), .io(io));
	dual_irq_ops u_dual_irq_ops (.sys_clk(sys_clk), .rst_n(rst_n), .io(io),
		.irq_in(irq_in), .io_rdata(io_rdata), .cpu_int(cpu_int),
		.special_mask_low(special_mask_low), .special_mask_high(special_mask_high));

	// --------------------------------
	// Clock, watchdog, helpers
	// --------------------------------
	always #5 sys_clk = ~sys_clk;
	// Whole run needs well under 2000 cycles
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 2000) begin
			mismatches++;
			close_out();
		end
	end
	task automatic check(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
		u_io_host.rd(a, got);
		check(got, e);
	endtask
	task automatic init_ctl(input logic [15:0] b, input logic [7:0] w3);
		u_io_host.wr(b, 8'h11);
		u_io_host.wr(b + 16'h1, 8'h08);
		u_io_host.wr(b + 16'h1, w3);
		u_io_host.wr(b + 16'h1, 8'h01);
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// --------------------------------
	// Main sequence
	// --------------------------------
	initial begin
		repeat (4) @(negedge sys_clk);
		rst_n = 1'b1;
		rd_chk(PORT_TRIG_LOW, TRIG_RESET);
		rd_chk(PORT_CTL1_BASE, 8'h00);
		init_ctl(PORT_CTL1_BASE, 8'h04);
		init_ctl(PORT_CTL2_BASE, 8'h02);
		for (int i = 0; i < 7; i++) begin
			u_io_host.wr(rows[i][31:16], rows[i][15:8]);
			rd_chk(rows[i][31:16], rows[i][7:0]);
		end
		// Level line 3 pends while high, survives poll and END_OF_INTERRUPT
		u_io_host.wr(PORT_TRIG_LOW, 8'h08);
		irq_in[3] = 1'b1;
		repeat (3) @(negedge sys_clk);
		check({7'h00, cpu_int}, 8'h01);
		rd_chk(PORT_CTL1_BASE, 8'h08);
		u_io_host.poll(PORT_CTL1_BASE, got);
		check(got, 8'h83);
		u_io_host.cmd3(PORT_CTL1_BASE, 8'h03);
		rd_chk(PORT_CTL1_BASE, 8'h08);
		rd_chk(PORT_CTL1_BASE, 8'h08);
		u_io_host.cmd2(PORT_CTL1_BASE, 8'h63);
		rd_chk(PORT_CTL1_BASE, 8'h00);
		u_io_host.cmd3(PORT_CTL1_BASE, 8'h02);
		rd_chk(PORT_CTL1_BASE, 8'h08);
		irq_in[3] = 1'b0;
		repeat (3) @(negedge sys_clk);
		rd_chk(PORT_CTL1_BASE, 8'h00);
		u_io_host.wr(PORT_TRIG_LOW, 8'h00);
		// Priority moved so line 4 outranks line 1
		u_io_host.cmd2(PORT_CTL1_BASE, 8'hC3);
		@(negedge sys_clk) irq_in = 16'h0012;
		@(negedge sys_clk) irq_in = 16'h0000;
		u_io_host.poll(PORT_CTL1_BASE, got);
		check(got, 8'h84);
		u_io_host.poll(PORT_CTL1_BASE, got);
		check(got, 8'h81);
		u_io_host.cmd2(PORT_CTL1_BASE, 8'h20);
		u_io_host.cmd2(PORT_CTL1_BASE, 8'h20);
		u_io_host.cmd3(PORT_CTL1_BASE, 8'h03);
		rd_chk(PORT_CTL1_BASE, 8'h00);
		u_io_host.cmd2(PORT_CTL1_BASE, 8'hC7);
		// Every rotate code on the second controller, then one request
		for (int k = 0; k < 8; k++)
			u_io_host.cmd2(PORT_CTL2_BASE, {k[2:0], 5'h07});
		@(negedge sys_clk) irq_in[9] = 1'b1;
		@(negedge sys_clk) irq_in[9] = 1'b0;
		u_io_host.poll(PORT_CTL2_BASE, got);
		check(got, 8'h81);
		// Special mask needs both bits; init word clears it
		// The mode pin follows the write by one more cycle, so wait before looking
		u_io_host.cmd3(PORT_CTL1_BASE, 8'h60);
		@(negedge sys_clk);
		check({7'h00, special_mask_low}, 8'h01);
		u_io_host.cmd3(PORT_CTL1_BASE, 8'h40);
		@(negedge sys_clk);
		check({7'h00, special_mask_low}, 8'h01);
		u_io_host.cmd3(PORT_CTL1_BASE, 8'h20);
		@(negedge sys_clk);
		check({7'h00, special_mask_low}, 8'h00);
		u_io_host.cmd3(PORT_CTL2_BASE, 8'h60);
		@(negedge sys_clk);
		check({7'h00, special_mask_high}, 8'h01);
		init_ctl(PORT_CTL2_BASE, 8'h02);
		check({7'h00, special_mask_high}, 8'h00);
		close_out();
	end
endmodule
`default_nettype wire
